// ===== tb_three_wire_serial_channel.sv
// self-checking bench for the three-wire serial channel
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_three_wire_serial_channel;
  logic                  sys_clk;
  logic                  reset_n;
  tws_pkg::tws_cpu_req_s req;
  logic            [7:0] buf_rdata;
  logic                  transfer_end_flag;
  logic                  transfer_end_clr;
  logic                  rx_valid;
  logic                  rx_ready;
  logic            [7:0] rx_data;
  tws_pkg::tws_pin_out_s pin_out;
  logic                  sck_line;
  logic                  miso;
  logic                  ext_sck;
  logic            [7:0] peer_rx;
  int                    mismatches;
  int                    checks_done;
  int                    n;

  // 40 MHz clock
  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  // clock wire: the channel drives it only when its output enable is high
  assign sck_line = pin_out.sck_oe ? pin_out.sck_o : ext_sck;

  tws_channel DUT (
    .sys_clk            (sys_clk),
    .reset_n            (reset_n),
    .cpu_req            (req),
    .buf_rdata          (buf_rdata),
    .transfer_end_flag  (transfer_end_flag),
    .transfer_end_clr   (transfer_end_clr),
    .rx_valid           (rx_valid),
    .rx_ready           (rx_ready),
    .rx_data            (rx_data),
    .serial_clock_pin_i (sck_line),
    .serial_in_pin      (miso),
    .pin_out            (pin_out)
  );

  tws_peer peer (
    .sys_clk  (sys_clk),
    .sck_line (sck_line),
    .mosi     (pin_out.so_o),
    .miso     (miso),
    .ext_sck  (ext_sck),
    .rx_byte  (peer_rx)
  );

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #2;
  endtask

  // strobes rise for one edge, then a spare edge so tasks never collide
  task automatic wr_mode(input logic [7:0] v);
    req.mode_wr = 1'b1;
    req.mode_wdata = v & 8'h83;
    tick(1);
    req.mode_wr = 1'b0;
    tick(1);
  endtask

  task automatic wr_buf(input logic [7:0] v);
    req.buf_wr = 1'b1;
    req.buf_wdata = v;
    tick(1);
    req.buf_wr = 1'b0;
    tick(1);
  endtask

  task automatic clr_flag();
    transfer_end_clr = 1'b1;
    tick(1);
    transfer_end_clr = 1'b0;
    tick(1);
  endtask

  // bounded wait for the end flag; the count is the elapsed cycles
  task automatic wait_flag(input int lim);
    n = 0;
    while (transfer_end_flag !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
  endtask

  task automatic test_reset();
    `CHK(pin_out, 4'b1000)
    `CHK(transfer_end_flag, 1'b0)
    `CHK(rx_valid, 1'b0)
    $display("test reset done");
  endtask

  // halted channel stores plainly; enabling afterwards starts nothing
  task automatic test_halt();
    wr_mode(8'h02);
    wr_buf(8'h5a);
    `CHK(buf_rdata, 8'h5a)
    `CHK(pin_out.so_oe, 1'b0)
    req.enable_wr = 1'b1;
    req.enable_wdata = 1'b1;
    tick(1);
    req.enable_wr = 1'b0;
    tick(2);
    `CHK(pin_out.so_oe, 1'b1)
    wait_flag(200);
    `CHK(transfer_end_flag, 1'b0)
    `CHK(pin_out.sck_o, 1'b1)
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    tick(2);
    `CHK(buf_rdata, 8'h5a)
    `CHK(pin_out.so_oe, 1'b0)
    $display("test halt done");
  endtask

  // divide by 16, with a refused write while the clock is low
  task automatic test_div16();
    peer.load(8'h3c);
    wr_mode(8'h82);
    `CHK(pin_out.sck_oe, 1'b1)
    wr_buf(8'ha5);
    n = 0;
    while (pin_out.sck_o !== 1'b0 && n < 40) begin
      tick(1);
      n++;
    end
    wr_buf(8'hff);
    wait_flag(400);
    // eight bits of sixteen cycles from the first write, less the 11 cycles spent above
    `CHK(n, 117)
    wait_flag(400);
    `CHK(transfer_end_flag, 1'b1)
    // the pin rises one cycle after the internal edge that sets the flag
    tick(2);
    `CHK(peer_rx, 8'ha5)
    `CHK(buf_rdata, 8'h3c)
    `CHK(rx_data, 8'h3c)
    tick(40);
    `CHK(pin_out.sck_o, 1'b1)
    rx_ready = 1'b1;
    tick(1);
    rx_ready = 1'b0;
    clr_flag();
    `CHK(transfer_end_flag, 1'b0)
    $display("test div16 done");
  endtask

  // divide by 8: fill the fifo until starts are refused, then drain it
  task automatic test_div8_fifo();
    wr_mode(8'h83);
    for (int i = 0; i < 4; i++) begin
      peer.load(8'h10 + i[7:0]);
      wr_buf(8'hc0 + i[7:0]);
      wait_flag(400);
      `CHK((n >= 58 && n <= 72), 1'b1)
      // let the last clock rise reach the peer before judging its byte
      tick(2);
      `CHK(peer_rx, 8'hc0 + i[7:0])
      clr_flag();
    end
    wr_buf(8'h77);
    wait_flag(150);
    `CHK(transfer_end_flag, 1'b0)
    for (int i = 0; i < 4; i++) begin
      `CHK(rx_valid, 1'b1)
      `CHK(rx_data, 8'h10 + i[7:0])
      rx_ready = 1'b1;
      tick(1);
      rx_ready = 1'b0;
      tick(1);
    end
    `CHK(rx_valid, 1'b0)
    $display("test div8 fifo done");
  endtask

  // external clock from the peer, pin left as input
  task automatic test_external();
    wr_mode(8'h80);
    `CHK(pin_out.sck_oe, 1'b0)
    peer.load(8'h96);
    wr_buf(8'h69);
    peer.ext_frame(8);
    wait_flag(20);
    `CHK(transfer_end_flag, 1'b1)
    `CHK(peer_rx, 8'h69)
    tick(2);
    `CHK(rx_data, 8'h96)
    $display("test external done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog sized well beyond the expected thousand or so cycles
  initial begin
    #(25 * 20000);
    mismatches++;
    give_verdict();
  end

  initial begin
    mismatches = 0;
    checks_done = 0;
    req = '0;
    transfer_end_clr = 1'b0;
    rx_ready = 1'b0;
    reset_n = 1'b0;
    tick(3);
    test_reset();
    reset_n = 1'b1;
    tick(1);
    test_halt();
    test_div16();
    test_div8_fifo();
    test_external();
    give_verdict();
  end
endmodule

// ===== tws_channel.sv
// three-wire serial channel: mode register, shift buffer, clocking and pins
`timescale 1ns/10ps
// Function
// - both clock selects zero: clock taken from the external pin, pin is input.
// - high select set: drive clock pin, system clock divided by 16 or 8.
// - enable zero: no shifting, bit counter cleared, end flag held.
// - enable one: shifting and bit counting run, end flag may be set.
// - reset clears the mode register, channel halted.
// - mode register written whole; enable bit also writable alone.
// - writing the shift buffer starts a transfer, most significant bit first.
// - shift buffer not touched by reset, so standby contents survive.
// - shifting stops by itself after eight bits.
// - a write starts a transfer only if enable is already one.
// - buffer write starts only with clock masked after transfer or clock high.
// - halted channel never shifts; buffer acts as plain register.
// - after reset serial out and in pins are inputs only.
// - update serial out on each clock falling edge; the buffer shifts on the rising edge.
// - sample serial in on each clock rising edge, full duplex.
// - after eight bits the transfer ends and the end flag is set.
// - end flag gives no wake-up from standby.
module tws_channel (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  // processor register accesses
  input  wire tws_pkg::tws_cpu_req_s cpu_req,
  output logic                      [7:0] buf_rdata,
  output logic                      transfer_end_flag,
  input  wire logic                 transfer_end_clr,
  // received bytes
  output logic                      rx_valid,
  input  wire logic                 rx_ready,
  output logic                      [7:0] rx_data,
  // pins
  input  wire logic                 serial_clock_pin_i,
  input  wire logic                 serial_in_pin,
  output tws_pkg::tws_pin_out_s     pin_out
);

  logic [7:0]          mode_r;
  logic [7:0]          shift_r;
  logic [2:0]          bit_cnt_r;
  logic [2:0]          div_cnt_r;
  logic                sck_int_r;
  logic                sck_prev_r;
  logic                eot_r;
  logic [7:0]          rdata_r;
  tws_pkg::tws_state_e state_r;
  tws_pkg::tws_pin_out_s pins_r;
  logic [1:0]          pins_s;
  logic                sck_s;
  logic                si_s;
  logic                enable;
  logic                internal;
  logic [2:0]          half_last;
  logic                tick;
  logic                sck_level;
  logic                fall_ev;
  logic                rise_ev;
  logic                write_ok;
  logic                start;
  logic                done;
  logic                fifo_ready;

  // mode fields
  assign enable    = mode_r[tws_pkg::ENABLE_BIT];
  assign internal  = mode_r[tws_pkg::CLK_SEL_HI_BIT];
  assign half_last = mode_r[tws_pkg::CLK_SEL_LO_BIT] ? tws_pkg::DIV8_HALF_LAST
                                                     : tws_pkg::DIV16_HALF_LAST;

  // pin inputs cross into sys_clk before anyone looks at them
  tws_sync #(
    .WIDTH (tws_pkg::SYNC_STAGES_W)
  ) u_sync (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .async_in ({serial_clock_pin_i, serial_in_pin}),
    .sync_out (pins_s)
  );
  assign sck_s = pins_s[1];
  assign si_s  = pins_s[0];

  // clock edges from the divider or from the synchronised external pin
  assign tick      = (state_r == tws_pkg::TWS_SHIFT) && (div_cnt_r == half_last);
  assign sck_level = internal ? sck_int_r : sck_s;
  assign fall_ev   = internal ? (tick && sck_int_r) : (sck_prev_r && !sck_s);
  assign rise_ev   = internal ? (tick && !sck_int_r) : (!sck_prev_r && sck_s);

  // a write is honoured only while the clock is masked or high
  assign write_ok = (state_r == tws_pkg::TWS_IDLE) || sck_level;
  // start also needs room for the received byte, so the fifo back-pressures
  assign start = cpu_req.buf_wr && write_ok && enable && fifo_ready;
  assign done  = (state_r == tws_pkg::TWS_SHIFT) && rise_ev && (bit_cnt_r == tws_pkg::LAST_BIT);

  // mode register: whole-byte write, enable bit alone by bit write
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= tws_pkg::MODE_RESET;
    end else if (cpu_req.mode_wr) begin
      mode_r <= cpu_req.mode_wdata;
    end else if (cpu_req.enable_wr) begin
      mode_r[tws_pkg::ENABLE_BIT] <= cpu_req.enable_wdata;
    end
  end

  // transfer state and bit counter
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= tws_pkg::TWS_IDLE;
      bit_cnt_r <= '0;
    end else if (!enable) begin
      state_r   <= tws_pkg::TWS_IDLE;
      bit_cnt_r <= '0;
    end else if (start) begin
      state_r   <= tws_pkg::TWS_SHIFT;
      bit_cnt_r <= '0;
    end else if (done) begin
      state_r   <= tws_pkg::TWS_IDLE;
      bit_cnt_r <= '0;
    end else if (state_r == tws_pkg::TWS_SHIFT && rise_ev) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  // internal clock divider; idles high so a masked clock reads as high
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_r <= '0;
      sck_int_r <= 1'b1;
    end else if (state_r != tws_pkg::TWS_SHIFT || start) begin
      div_cnt_r <= '0;
      sck_int_r <= 1'b1;
    end else if (tick) begin
      div_cnt_r <= '0;
      sck_int_r <= !sck_int_r;
    end else begin
      div_cnt_r <= div_cnt_r + 3'h1;
    end
  end

  // previous synchronised clock level for external edge detection
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_prev_r <= 1'b1;
    end else begin
      sck_prev_r <= sck_s;
    end
  end

  // shift buffer has no reset so its contents survive a standby reset
  always_ff @(posedge sys_clk) begin
    if (cpu_req.buf_wr && (write_ok || !enable)) begin
      shift_r <= cpu_req.buf_wdata;
    end else if (state_r == tws_pkg::TWS_SHIFT && enable && rise_ev) begin
      shift_r <= {shift_r[6:0], si_s};
    end
  end

  // end flag: set wins over a clear in the same cycle; no wake output exists
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      eot_r <= 1'b0;
    end else if (done && enable) begin
      eot_r <= 1'b1;
    end else if (transfer_end_clr) begin
      eot_r <= 1'b0;
    end
  end

  // pin drive; serial out changes only on falling edges
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pins_r <= '0;
      pins_r.sck_o <= 1'b1;
    end else begin
      pins_r.sck_oe <= internal;
      pins_r.sck_o  <= sck_int_r;
      pins_r.so_oe  <= enable;
      if (state_r == tws_pkg::TWS_SHIFT && enable && fall_ev) begin
        pins_r.so_o <= shift_r[7];
      end
    end
  end

  // registered read-back of the shift buffer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= shift_r;
    end
  end

  // each finished byte lands in the receive fifo
  tws_fifo #(
    .WIDTH (tws_pkg::BYTE_W),
    .DEPTH (tws_pkg::RX_DEPTH)
  ) u_rx_fifo (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .in_valid  (done && enable),
    .in_ready  (fifo_ready),
    .in_data   ({shift_r[6:0], si_s}),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  assign pin_out           = pins_r;
  assign buf_rdata         = rdata_r;
  assign transfer_end_flag = eot_r;

  // single-cycle sequences used below
  sequence s_last_rise;
    state_r == tws_pkg::TWS_SHIFT && rise_ev && bit_cnt_r == tws_pkg::LAST_BIT && enable;
  endsequence

  sequence s_stopped;
    state_r == tws_pkg::TWS_IDLE && eot_r;
  endsequence

  a_mode_reset_zero: assert property (@(posedge sys_clk)
    $rose(reset_n) |-> mode_r == tws_pkg::MODE_RESET)
    else $error("mode register not zero after reset");

  a_halt_clears_cnt: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !enable |=> state_r == tws_pkg::TWS_IDLE && bit_cnt_r == 3'h0)
    else $error("halted channel still counting");

  a_flag_needs_enable: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(eot_r) |-> $past(enable) && $past(state_r) == tws_pkg::TWS_SHIFT)
    else $error("end flag set without enabled transfer");

  a_eight_bits_end: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_last_rise |=> s_stopped)
    else $error("transfer did not end after eighth bit");

  a_start_needs_en: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(state_r == tws_pkg::TWS_SHIFT) |-> $past(enable) && $past(cpu_req.buf_wr))
    else $error("transfer started without enabled write");

  a_so_on_fall: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_r == tws_pkg::TWS_SHIFT && fall_ev && enable |=> pins_r.so_o == $past(shift_r[7]))
    else $error("serial out not updated on falling edge");

  a_si_on_rise: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_r == tws_pkg::TWS_SHIFT && rise_ev && enable && !cpu_req.buf_wr
      |=> shift_r[0] == $past(si_s))
    else $error("serial in not sampled on rising edge");

  a_halted_plain_reg: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cpu_req.buf_wr && !enable |=> shift_r == $past(cpu_req.buf_wdata))
    else $error("halted buffer write not stored");

  a_div16_spacing: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tick && mode_r[1:0] == 2'b10 && !start ##1 mode_r[1:0] == 2'b10 |-> !tick [*7])
    else $error("divide by 16 half period wrong");

  a_div8_spacing: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tick && mode_r[1:0] == 2'b11 && !start ##1 mode_r[1:0] == 2'b11 |-> !tick [*3])
    else $error("divide by 8 half period wrong");

  a_sck_direction: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ##1 pins_r.sck_oe == $past(internal))
    else $error("clock pin direction does not follow mode");

  // mode writes, halted pins, clock masking and room for the received byte
  a_mode_whole_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cpu_req.mode_wr |=> mode_r == $past(cpu_req.mode_wdata))
    else $error("mode register byte write lost");

  a_flag_held_halt: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !enable && !transfer_end_clr |=> eot_r == $past(eot_r))
    else $error("end flag changed while halted");

  a_halt_so_still: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !enable |=> $stable(pins_r.so_o))
    else $error("serial out moved while halted");

  a_full_no_start: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cpu_req.buf_wr && !fifo_ready |=> state_r == tws_pkg::TWS_IDLE)
    else $error("transfer started with receive fifo full");

  a_sck_idle_high: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_r == tws_pkg::TWS_IDLE |=> sck_int_r)
    else $error("internal clock not masked high when idle");

  a_div_masked: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_r != tws_pkg::TWS_SHIFT |=> div_cnt_r == 3'h0)
    else $error("divider running outside a transfer");

  a_ext_sck_input: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !mode_r[tws_pkg::CLK_SEL_HI_BIT] && !mode_r[tws_pkg::CLK_SEL_LO_BIT] |=> !pins_r.sck_oe)
    else $error("clock pin driven in external clock mode");

  a_int_sck_output: assert property (@(posedge sys_clk) disable iff (!reset_n)
    mode_r[tws_pkg::CLK_SEL_HI_BIT] |=> pins_r.sck_oe)
    else $error("clock pin not driven in internal clock mode");

  a_last_push_room: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_last_rise |-> fifo_ready)
    else $error("finished byte found no room in fifo");

endmodule

// ===== tws_fifo.sv
// small valid/ready fifo holding received bytes
`timescale 1ns/10ps
module tws_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW:0]      count_r;
  logic             push;
  logic             pop;

  // honest flags straight from the occupancy count
  assign in_ready  = (count_r != DEPTH[PW:0]);
  assign out_valid = (count_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rd_ptr_r];

  // storage carries data only, no reset needed
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // pointers wrap naturally since depth is a power of two
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

// ===== tws_peer.sv
// behavioural model of the peripheral on the far side of the serial lines
`timescale 1ns/10ps
module tws_peer (
  // timing reference
  input  wire logic       sys_clk,
  // serial lines
  input  wire logic       sck_line,
  input  wire logic       mosi,
  output logic            miso,
  output logic            ext_sck,
  // byte received in the last frame
  output logic      [7:0] rx_byte
);
  logic [7:0] tx;
  int         idx;

  // idle clock stands high between frames
  initial begin
    ext_sck = 1'b1;
    miso    = 1'b0;
    rx_byte = 8'h00;
    tx      = 8'h00;
    idx     = 7;
  end

  // stage the next byte to send, msb goes out first
  task automatic load(input logic [7:0] b);
    tx  = b;
    idx = 7;
  endtask

  // data changes on the falling clock edge
  always @(negedge sck_line) begin
    miso = tx[idx];
  end

  // data sampled on the rising edge; 50 ns after the last bit the line is inverted
  always @(posedge sck_line) begin
    rx_byte = {rx_byte[6:0], mosi};
    if (idx == 0) begin
      idx = 7;
      #50 miso = ~miso;
    end else begin
      idx--;
    end
  end

  // one external clock frame of eight bits, half period in sys_clk cycles
  task automatic ext_frame(input int half);
    for (int b = 0; b < 8; b++) begin
      ext_sck = 1'b0;
      repeat (half) @(posedge sys_clk);
      #2 ext_sck = 1'b1;
      repeat (half) @(posedge sys_clk);
      #2;
    end
  endtask
endmodule

// ===== tws_pkg.sv
// shared constants and carrier types for the three-wire serial channel
package tws_pkg;

  // serial_mode_control layout and reset value
  localparam logic [7:0] MODE_RESET      = 8'h00;
  localparam int         ENABLE_BIT      = 7;
  localparam int         CLK_SEL_HI_BIT  = 1;
  localparam int         CLK_SEL_LO_BIT  = 0;

  // internal clock: last divider count of each half period in sys_clk cycles (divide by 16 and by 8)
  localparam logic [2:0] DIV16_HALF_LAST = 3'h7;
  localparam logic [2:0] DIV8_HALF_LAST  = 3'h3;

  // bits per transfer, receive buffer shape and synchroniser width
  localparam logic [2:0] LAST_BIT        = 3'h7;
  localparam int         BYTE_W          = 8;
  localparam int         RX_DEPTH        = 4;
  localparam int         SYNC_STAGES_W   = 2;

  // channel state
  typedef enum logic [0:0] {
    TWS_IDLE  = 1'b0,
    TWS_SHIFT = 1'b1
  } tws_state_e;

  // processor-side register accesses, one cycle each
  typedef struct packed {
    logic       mode_wr;
    logic [7:0] mode_wdata;
    logic       enable_wr;
    logic       enable_wdata;
    logic       buf_wr;
    logic [7:0] buf_wdata;
  } tws_cpu_req_s;

  // pin drive towards the pads
  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic so_o;
    logic so_oe;
  } tws_pin_out_s;

endpackage

// ===== tws_sync.sv
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/10ps
module tws_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r   <= '1;
      sync_out <= '1;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule
